// ---- supervision_reaction.sv ----
// Reset and supply supervision reaction logic with an APB register slave
// What this block does
// - Normal operation after reset release, no fault
// - Internal undervoltage: reset low, clear, flag set
// - Internal undervoltage flag clears on first read
// - Clock fail: reset low, clear, flag set
// - Clock-fail flag clears on first read
// - Supply or external reset: clear, keep flags
// - Hold reset reaction through fault and recovery
// - Recovery starts after internal, logic and I/O supplies are good
// - Power undervoltage: no reset, clear setpoints
// - Every reset-cause flag clears on read
// - Clock monitor restarts after its flag clears
// - Release reset line after recovery period
// - Filter reset input glitches under two microseconds
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module supervision_reaction
    import supervision_pkg::*;
#(
    parameter int RECOVERY_CYCLES = RECOVERY_CYCLES_DEF
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          internal_supply_uv,
    input  wire logic                          logic_supply_uv,
    input  wire logic                          io_supply_uv,
    input  wire logic                          power_supply_uv,
    input  wire logic                          clock_fail_det,
    input  wire logic                          reset_line_n_in,
    output logic                               reset_line_n_out,
    output logic                               reset_line_n_oe_n,
    output logic                               clock_monitor_en,
    output drive_t                             drive,
    output logic      [NUM_VALVES*SETPT_W-1:0] valve_setpoint
);

    localparam int REC_W = $clog2(RECOVERY_CYCLES + 1);
    localparam int EXT_W = $clog2(EXT_FILTER_CYCLES + 1);
    localparam int SP_W  = NUM_VALVES * SETPT_W;

    typedef struct packed {
        phase_t            phase;
        logic [FLAG_W-1:0] flags;
        logic              locked;
        logic              int_drive;
        logic [CTRL_W-1:0] ctrl;
        logic [SP_W-1:0]   setpt;
        logic [REC_W-1:0]  rec_cnt;
        logic [EXT_W-1:0]  ext_cnt;
        logic              ext_active;
        logic              line_oe_n;
        logic              clk_mon_en;
        drive_t            drv;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } state_t;

    state_t s;
    state_t next_s;

    logic access;
    logic rd_flags;
    logic clk_evt;
    logic int_fault;
    logic any_fault;
    logic [FLAG_W-1:0] set_flags;

    // ==========================================================
    // Event decode
    assign access    = psel && penable && !s.pready;
    assign rd_flags  = access && !pwrite && paddr == REG_FLAGS;
    assign clk_evt   = clock_fail_det && s.clk_mon_en;
    assign int_fault = internal_supply_uv || logic_supply_uv || io_supply_uv;
    assign any_fault = int_fault || clk_evt || s.ext_active;

    always_comb begin
        set_flags = '0;
        set_flags[LOGIC_SUPPLY_UV_FLAG_BIT] = logic_supply_uv;
        set_flags[IO_SUPPLY_UV_FLAG_BIT]    = io_supply_uv;
        set_flags[EXT_RESET_FLAG_BIT]       = s.ext_active;
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;

        // External reset filter, ignored while the device drives the line
        if (!reset_line_n_in && s.line_oe_n) begin
            if (s.ext_cnt != EXT_W'(EXT_FILTER_CYCLES)) begin
                next_s.ext_cnt = s.ext_cnt + 1'b1;
            end
            next_s.ext_active = (next_s.ext_cnt == EXT_W'(EXT_FILTER_CYCLES));
        end else begin
            next_s.ext_cnt    = '0;
            next_s.ext_active = 1'b0;
        end

        // APB access, answered one cycle into the access phase
        if (access) begin
            next_s.pready = 1'b1;
            next_s.prdata = '0;
            case (paddr)
                REG_FLAGS: begin
                    if (pwrite) begin
                        next_s.flags  = '0;
                        next_s.locked = 1'b0;
                    end else begin
                        next_s.prdata[FLAG_W-1:0] = s.flags;
                        next_s.flags = '0;
                    end
                end
                REG_CTRL: begin
                    if (pwrite && !s.locked) begin
                        next_s.ctrl = pwdata[CTRL_W-1:0];
                    end
                    next_s.prdata[CTRL_W-1:0] = s.ctrl;
                end
                REG_SETPT: begin
                    if (pwrite && !s.locked) begin
                        next_s.setpt = pwdata[SP_W-1:0];
                    end
                    next_s.prdata[SP_W-1:0] = s.setpt;
                end
                REG_STATE: begin
                    next_s.prdata[DRIVE_W+$bits(phase_t)+1:0] = {s.phase, s.int_drive, s.locked,
                        s.drv};
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end

        // Fault effects override software, so a set wins over a clear
        if (internal_supply_uv) begin
            next_s.flags = '0;
            next_s.flags[INTERNAL_SUPPLY_UV_FLAG_BIT] = 1'b1;
        end else if (clk_evt) begin
            next_s.flags = '0;
            next_s.flags[INTERNAL_SUPPLY_UV_FLAG_BIT] = s.flags[INTERNAL_SUPPLY_UV_FLAG_BIT]
                && !rd_flags;
            next_s.flags[CLOCK_FAIL_FLAG_BIT] = 1'b1;
        end
        next_s.flags = next_s.flags | set_flags;
        if (any_fault) begin
            next_s.ctrl   = CTRL_RESET;
            next_s.setpt  = '0;
            next_s.locked = 1'b1;
        end
        if (power_supply_uv) begin
            next_s.setpt = '0;
            next_s.ctrl[CTRL_PUMP_BIT] = 1'b1;
        end

        // Reaction sequence
        case (s.phase)
            PH_NORMAL: begin
                if (any_fault) begin
                    next_s.phase = PH_FAULT;
                end
            end
            PH_FAULT: begin
                if (!any_fault) begin
                    next_s.phase   = PH_RECOVER;
                    next_s.rec_cnt = '0;
                end
            end
            PH_RECOVER: begin
                if (any_fault) begin
                    next_s.phase = PH_FAULT;
                end else if (s.rec_cnt == REC_W'(RECOVERY_CYCLES - 1)) begin
                    next_s.phase = PH_NORMAL;
                end else begin
                    next_s.rec_cnt = s.rec_cnt + 1'b1;
                end
            end
            default: begin
                next_s.phase = PH_FAULT;
            end
        endcase

        // Device drives the line only for its own causes
        if (int_fault || clk_evt) begin
            next_s.int_drive = 1'b1;
        end else if (next_s.phase == PH_NORMAL) begin
            next_s.int_drive = 1'b0;
        end
        next_s.line_oe_n = !next_s.int_drive;

        if (next_s.phase == PH_NORMAL) begin
            next_s.drv.valve_drivers         = next_s.ctrl[CTRL_VALVE_LSB +: NUM_VALVES];
            next_s.drv.pump_predriver        = next_s.ctrl[CTRL_PUMP_BIT];
            next_s.drv.resistive_load_driver = next_s.ctrl[CTRL_LOAD_LSB +: NUM_LOADS];
        end else begin
            next_s.drv = '0;
        end
        next_s.clk_mon_en = next_s.phase == PH_NORMAL && !next_s.ctrl[CTRL_CLKSTOP]
            && !next_s.flags[CLOCK_FAIL_FLAG_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{phase: PH_NORMAL, ctrl: CTRL_RESET, line_oe_n: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata            = s.prdata;
    assign pready            = s.pready;
    assign pslverr           = s.pslverr;
    assign reset_line_n_out  = s.int_drive && 1'b0;
    assign reset_line_n_oe_n = s.line_oe_n;
    assign clock_monitor_en  = s.clk_mon_en;
    assign drive             = s.drv;
    assign valve_setpoint    = s.setpt;

    // ==========================================================
    // Assertions
    property p_normal_follows_ctrl;
        @(posedge pclk) disable iff (!presetn)
        (s.phase == PH_NORMAL) |-> (drive.valve_drivers == s.ctrl[CTRL_VALVE_LSB +: NUM_VALVES]);
    endproperty
    a_normal_follows_ctrl: assert property (p_normal_follows_ctrl)
        else $error("valve outputs differ from control in normal phase");

    property p_int_uv;
        @(posedge pclk) disable iff (!presetn)
        (internal_supply_uv && !power_supply_uv) |=> (s.flags[INTERNAL_SUPPLY_UV_FLAG_BIT]
            && !reset_line_n_oe_n
            && drive == '0 && s.ctrl == CTRL_RESET);
    endproperty
    a_int_uv: assert property (p_int_uv)
        else $error("internal undervoltage reaction missing");

    property p_read_clears;
        @(posedge pclk) disable iff (!presetn)
        (rd_flags && !internal_supply_uv && !clk_evt && set_flags == '0) |=> (s.flags == '0);
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("flags not cleared on read");

    property p_clk_fail;
        @(posedge pclk) disable iff (!presetn)
        (clk_evt && !internal_supply_uv) |=> (s.flags[CLOCK_FAIL_FLAG_BIT] && !reset_line_n_oe_n
            && !clock_monitor_en);
    endproperty
    a_clk_fail: assert property (p_clk_fail)
        else $error("clock fail reaction missing");

    property p_monitor_gated;
        @(posedge pclk) disable iff (!presetn)
        clock_monitor_en |-> (!s.flags[CLOCK_FAIL_FLAG_BIT] && s.phase == PH_NORMAL);
    endproperty
    a_monitor_gated: assert property (p_monitor_gated)
        else $error("clock monitor running with flag set");

    property p_supply_keep;
        @(posedge pclk) disable iff (!presetn)
        (logic_supply_uv && !internal_supply_uv && !clk_evt
            && !(access && paddr == REG_FLAGS)) |=>
            (s.flags == ($past(s.flags) | $past(set_flags)) && drive == '0);
    endproperty
    a_supply_keep: assert property (p_supply_keep)
        else $error("supply undervoltage lost a flag");

    property p_fault_holds;
        @(posedge pclk) disable iff (!presetn)
        any_fault |=> (s.phase == PH_FAULT) ##1 (drive == '0);
    endproperty
    a_fault_holds: assert property (p_fault_holds)
        else $error("fault did not hold reaction");

    property p_power_uv;
        @(posedge pclk) disable iff (!presetn)
        power_supply_uv |=> (s.setpt == '0 && s.ctrl[CTRL_PUMP_BIT]);
    endproperty
    a_power_uv: assert property (p_power_uv)
        else $error("power undervoltage reaction missing");

    property p_ext_filter;
        @(posedge pclk) disable iff (!presetn)
        $rose(s.ext_active) |-> ($past(s.ext_cnt) == EXT_W'(EXT_FILTER_CYCLES - 1));
    endproperty
    a_ext_filter: assert property (p_ext_filter)
        else $error("external reset accepted before filter time");

    property p_recovery_len;
        @(posedge pclk) disable iff (!presetn)
        ($past(s.phase) == PH_RECOVER && s.phase == PH_NORMAL) |->
            ($past(s.rec_cnt) == REC_W'(RECOVERY_CYCLES - 1));
    endproperty
    a_recovery_len: assert property (p_recovery_len)
        else $error("recovery period wrong length");

endmodule

// ---- supervision_pkg.sv ----
// Constants, register map and carrier types for the supervision reaction block
package supervision_pkg;

    // ==========================================================
    // Register map (APB byte addresses)
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_CTRL  = 8'h04;
    localparam logic [7:0] REG_SETPT = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0c;

    // ==========================================================
    // Reset-cause flag positions
    localparam int FLAG_W                      = 5;
    localparam int INTERNAL_SUPPLY_UV_FLAG_BIT = 0;
    localparam int CLOCK_FAIL_FLAG_BIT         = 1;
    localparam int LOGIC_SUPPLY_UV_FLAG_BIT    = 2;
    localparam int IO_SUPPLY_UV_FLAG_BIT       = 3;
    localparam int EXT_RESET_FLAG_BIT          = 4;

    // ==========================================================
    // Control register layout
    localparam int CTRL_W         = 8;
    localparam int CTRL_VALVE_LSB = 0;
    localparam int CTRL_PUMP_BIT  = 4;
    localparam int CTRL_LOAD_LSB  = 5;
    localparam int CTRL_CLKSTOP   = 7;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

    // ==========================================================
    // Sizes and timing
    localparam int NUM_VALVES    = 4;
    localparam int NUM_LOADS     = 2;
    localparam int SETPT_W       = 8;
    localparam int CLK_PERIOD_NS = 20;
    localparam int EXT_FILTER_NS = 2000;
    localparam int EXT_FILTER_CYCLES = EXT_FILTER_NS / CLK_PERIOD_NS;
    localparam int RECOVERY_PERIOD_MS = 45;
    localparam int RECOVERY_CYCLES_DEF = RECOVERY_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

    // ==========================================================
    // Reaction phases
    typedef enum logic [2:0] {
        PH_NORMAL  = 3'b001,
        PH_FAULT   = 3'b010,
        PH_RECOVER = 3'b100
    } phase_t;

    typedef struct packed {
        logic [NUM_VALVES-1:0] valve_drivers;
        logic                  pump_predriver;
        logic [NUM_LOADS-1:0]  resistive_load_driver;
    } drive_t;

    localparam int DRIVE_W = $bits(drive_t);

endpackage

// ---- host_model.sv ----
// Host controller model on the far side of the reset wire
`timescale 1ns/1ps
module host_model (
    input  wire logic pclk,
    input  wire logic reset_line_n_out,
    input  wire logic reset_line_n_oe_n,
    output logic      reset_line_n_in
);
    logic host_low = 1'b0;

    // ==========================================================
    // Wire with pull-up: device pulls low when enabled, else host decides
    assign reset_line_n_in = reset_line_n_oe_n ? ~host_low : reset_line_n_out;

    // ==========================================================
    // External reset request, length in clock cycles
    task automatic hold_low(int n);
        host_low <= 1'b1;
        repeat (n) @(posedge pclk);
        host_low <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// ---- supervision_reaction_tb_top.sv ----
// Self-checking testbench of the supervision reaction block
`timescale 1ns/1ps
module supervision_reaction_tb_top
    import supervision_pkg::*;
;
    localparam int REC = 20;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, c;
    logic [31:0] pwdata, prdata, valve_setpoint, rd, seed, s;
    logic [3:0]  uv;
    logic        power_supply_uv, reset_line_n_in, reset_line_n_out, reset_line_n_oe_n;
    logic        clock_monitor_en;
    drive_t      drive;
    int          n_errors, comparisons;

    supervision_reaction #(.RECOVERY_CYCLES(REC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_supply_uv(uv[0]), .clock_fail_det(uv[1]), .logic_supply_uv(uv[2]),
        .io_supply_uv(uv[3]), .power_supply_uv(power_supply_uv),
        .reset_line_n_in(reset_line_n_in), .reset_line_n_out(reset_line_n_out),
        .reset_line_n_oe_n(reset_line_n_oe_n), .clock_monitor_en(clock_monitor_en),
        .drive(drive), .valve_setpoint(valve_setpoint)
    );

    host_model host (
        .pclk(pclk), .reset_line_n_out(reset_line_n_out),
        .reset_line_n_oe_n(reset_line_n_oe_n), .reset_line_n_in(reset_line_n_in)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] exp_drive(logic [7:0] v);
        drive_t d;
        d.valve_drivers         = v[CTRL_VALVE_LSB +: NUM_VALVES];
        d.pump_predriver        = v[CTRL_PUMP_BIT];
        d.resistive_load_driver = v[CTRL_LOAD_LSB +: NUM_LOADS];
        return 32'(d);
    endfunction

    task automatic stop_test();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic timeout(string name);
        n_errors++;
        $display("[FAIL] %s expected response seen none", name);
        stop_test();
    endtask

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) timeout("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(logic [7:0] a, logic [31:0] exp, string name);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    task automatic wait_oe(logic v, int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge pclk);
            if (reset_line_n_oe_n === v) break;
        end
        if (i == n) timeout("reset_line_n_oe_n");
    endtask

    // Reset-class fault on one supervised input, then full recovery
    task automatic fault(int k, int len);
        uv[k] <= 1'b1;
        repeat (len) @(posedge pclk);
        uv[k] <= 1'b0;
        repeat (2) @(posedge pclk);
        check("oe_n in fault", 32'(reset_line_n_oe_n), 32'h0);
        check("line_out in fault", 32'(reset_line_n_out), 32'h0);
        check("drive in fault", 32'(drive), 32'h0);
        repeat (REC - 1) @(posedge pclk);
        check("oe_n in recovery", 32'(reset_line_n_oe_n), 32'h0);
        check("drive in recovery", 32'(drive), 32'h0);
        wait_oe(1'b1, 1);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        uv = 4'h0;
        power_supply_uv = 1'b0;
        seed = 32'd10021;
        n_errors = 0;
        comparisons = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check("clock_monitor_en", 32'(clock_monitor_en), 32'h1);
        check("oe_n idle", 32'(reset_line_n_oe_n), 32'h1);
        rd_chk(REG_FLAGS, 32'h0, "flags after reset");
        apb(1'b0, 8'h10, 32'h0);
        check("pslverr", 32'(err), 32'h1);
        apb(1'b1, REG_FLAGS, 32'h0);
        for (int i = 0; i < 5; i++) begin
            c = (i == 0) ? 8'h7f : 8'(rnd()) & 8'h7f;
            s = rnd();
            apb(1'b1, REG_CTRL, 32'(c));
            apb(1'b1, REG_SETPT, s);
            repeat (2) @(posedge pclk);
            check("drive", 32'(drive), exp_drive(c));
            check("valve_setpoint", valve_setpoint, s);
            rd_chk(REG_CTRL, 32'(c), "ctrl");
        end
        fault(0, 5);
        rd_chk(REG_CTRL, 32'h0, "ctrl after uv");
        rd_chk(REG_SETPT, 32'h0, "setpt after uv");
        apb(1'b1, REG_CTRL, 32'h0f);
        rd_chk(REG_CTRL, 32'h0, "ctrl locked");
        fault(1, 1);
        check("monitor held", 32'(clock_monitor_en), 32'h0);
        rd_chk(REG_FLAGS, 32'h3, "flags uv clk");
        repeat (2) @(posedge pclk);
        check("monitor restart", 32'(clock_monitor_en), 32'h1);
        rd_chk(REG_FLAGS, 32'h0, "flags cleared");
        apb(1'b1, REG_FLAGS, 32'h0);
        apb(1'b1, REG_CTRL, 32'h0f);
        rd_chk(REG_CTRL, 32'h0f, "ctrl unlocked");
        rd_chk(REG_STATE, (32'(PH_NORMAL) << (DRIVE_W + 2)) | exp_drive(8'h0f), "state");
        fault(0, 3);
        uv[2] <= 1'b1;
        repeat (5) @(posedge pclk);
        uv[3] <= 1'b1;
        repeat (5) @(posedge pclk);
        uv[2] <= 1'b0;
        repeat (REC + 10) @(posedge pclk);
        check("oe_n overlap", 32'(reset_line_n_oe_n), 32'h0);
        uv[3] <= 1'b0;
        wait_oe(1'b1, REC + 20);
        rd_chk(REG_FLAGS, 32'hd, "flags kept");
        apb(1'b1, REG_FLAGS, 32'h0);
        apb(1'b1, REG_CTRL, 32'h0f);
        host.hold_low(50);
        repeat (4) @(posedge pclk);
        check("drive glitch", 32'(drive), exp_drive(8'h0f));
        host.hold_low(150);
        check("drive ext", 32'(drive), 32'h0);
        check("oe_n ext", 32'(reset_line_n_oe_n), 32'h1);
        repeat (REC + 10) @(posedge pclk);
        rd_chk(REG_FLAGS, 32'h10, "flags ext");
        apb(1'b1, REG_FLAGS, 32'h0);
        apb(1'b1, REG_CTRL, 32'h80);
        check("monitor stopped", 32'(clock_monitor_en), 32'h0);
        uv[1] <= 1'b1;
        @(posedge pclk);
        uv[1] <= 1'b0;
        repeat (2) @(posedge pclk);
        check("oe_n monitor stopped", 32'(reset_line_n_oe_n), 32'h1);
        c = 8'(rnd()) & 8'h6f;
        apb(1'b1, REG_CTRL, 32'(c));
        apb(1'b1, REG_SETPT, rnd() | 32'h1);
        power_supply_uv <= 1'b1;
        repeat (4) @(posedge pclk);
        check("setpt pwr uv", valve_setpoint, 32'h0);
        check("oe_n pwr uv", 32'(reset_line_n_oe_n), 32'h1);
        check("drive pwr uv", 32'(drive), exp_drive(c | 8'h10));
        power_supply_uv <= 1'b0;
        repeat (2) @(posedge pclk);
        stop_test();
    end
endmodule
